// ===== logic/asr_pkg.sv
// Constants shared by the converter readout control block.
// Assumes a single system clock domain at 10 MHz.
package asr_pkg;
   // =========================================================
   // Conversion timing
   localparam int MOD_DIV = 6;
   localparam int OSR = 64;
   localparam int CONV_CYCLES = MOD_DIV * OSR;
   localparam int SETTLE_CONVS = 5;
   localparam int RESULT_BITS = 24;
   localparam int SINC_ORDER = 5;
   // =========================================================
   // Hold-high decoding of the shift clock, in system clocks
   localparam int SYNC_HOLD = 4 * CONV_CYCLES;
   localparam int PDOWN_HOLD = 20 * CONV_CYCLES;
   // =========================================================
   // Reset values
   localparam logic [1:0] CHAN_RESET = 2'h0;
   localparam logic [23:0] RESULT_RESET = 24'h000000;
endpackage

// ===== logic/asr_sinc_filter.sv
// Sinc filter of order five decimating the modulator bitstream.
// Assumes mod_en pulses once per modulator cycle and dec_en once per
// result, coincident with an mod_en pulse.
module asr_sinc_filter #(
   parameter int OUT_W = 24, // Result width
   parameter int ACC_W = 32  // Integrator width
) (
   input wire logic clk,          // System clock
   input wire logic rst_n,        // Asynchronous reset, active low
   input wire logic ce,           // Clock enable
   input wire logic clear,        // Restart filter state
   input wire logic mod_en,       // Modulator sample strobe
   input wire logic mod_bit,      // Modulator bitstream
   input wire logic dec_en,       // Decimation strobe
   output logic [OUT_W-1:0] result // Two's complement result
);
   logic [ACC_W-1:0] integ [0:asr_pkg::SINC_ORDER-1];
   logic [ACC_W-1:0] comb_in [0:asr_pkg::SINC_ORDER];
   logic [ACC_W-1:0] delay [0:asr_pkg::SINC_ORDER-1];
   wire logic [ACC_W-1:0] sample = mod_bit ? ACC_W'(1) : '1;

   assign comb_in[0] = integ[asr_pkg::SINC_ORDER-1];

   // =========================================================
   // Integrators and combs
   genvar i;
   generate
      for (i = 0; i < asr_pkg::SINC_ORDER; i++) begin : g_stage
         wire logic [ACC_W-1:0] feed;
         if (i == 0) begin : g_first
            assign feed = sample;
         end else begin : g_next
            assign feed = integ[i-1];
         end
         assign comb_in[i+1] = comb_in[i] - delay[i];
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               integ[i] <= '0;
               delay[i] <= '0;
            end else if (ce) begin
               if (clear) begin
                  integ[i] <= '0;
                  delay[i] <= '0;
               end else begin
                  if (mod_en)
                     integ[i] <= integ[i] + feed;
                  if (dec_en)
                     delay[i] <= comb_in[i];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         result <= asr_pkg::RESULT_RESET;
      else if (ce && dec_en)
         result <= comb_in[asr_pkg::SINC_ORDER][ACC_W-1 -: OUT_W];
   end
endmodule

// ===== logic/asr_readout.sv
// Readout control of a four channel delta-sigma converter.
// Assumes SCLK, channel picks and modulator bit are synchronous inputs.
// Shift clock levels must each last at least two system clocks.
//
// Summary of operation
// - New result pulls ready line low only when idle with shift clock low.
// - Host clocks 24 result bits out serially.
// - Shift clock sampled by system clock, cannot outrun it.
// - Long shift clock high syncs or powers down.
// - Two pick pins choose analog channel.
// - Sinc5 filter writes results to output register.
// - Data rate follows system clock frequency.
// - Picks 00..11 select channels one to four.
// - Pick change restarts; valid after five conversions.
// - Divide by six, oversample 64: 384 clocks.
module asr_readout #(
   parameter int RES_W = asr_pkg::RESULT_BITS,  // Result width
   parameter int SYNC_HOLD = asr_pkg::SYNC_HOLD, // Clocks high to sync
   parameter int PDOWN_HOLD = asr_pkg::PDOWN_HOLD // Clocks high to power down
) (
   input wire logic SYS_CLK,          // System clock, 10 MHz
   input wire logic RST_N,            // Asynchronous reset, active low
   input wire logic CE,               // Clock enable, freezes all state
   input wire logic SHIFT_CLK,        // Host serial clock
   input wire logic CHANNEL_PICK_LO,  // Channel pick, low bit
   input wire logic CHANNEL_PICK_HI,  // Channel pick, high bit
   input wire logic MOD_BIT,          // Modulator bitstream
   output logic SERIAL_OUT_READY_LINE, // Data out / ready, low = ready
   output logic [1:0] CHANNEL,        // Channel routed to modulator
   output logic MOD_RESET,            // Modulator reset pulse
   output logic POWER_DOWN            // Power-down state
);
   typedef enum logic [2:0] {
      ST_WAIT  = 3'b001,
      ST_READY = 3'b010,
      ST_SHIFT = 3'b100
   } asr_state_type;

   asr_state_type state;
   asr_state_type next_state;
   logic [8:0] div_cnt;
   logic [2:0] settle;
   logic [RES_W-1:0] shreg;
   logic [4:0] bits_left;
   logic sclk_q;
   logic [1:0] pick_q;
   logic [1:0] pick_fall;
   logic [31:0] hold_cnt;
   logic [RES_W-1:0] result;

   // =========================================================
   // Pick and shift clock decoding
   wire logic [1:0] pick = {CHANNEL_PICK_HI, CHANNEL_PICK_LO};
   wire logic pick_change = pick_fall != pick_q;
   // Edges found against the previous sample
   wire logic sclk_rise = SHIFT_CLK && !sclk_q;
   wire logic sclk_fall = !SHIFT_CLK && sclk_q;
   wire logic sync_hit = SHIFT_CLK && hold_cnt == 32'(SYNC_HOLD - 1);
   wire logic pdown_hit = SHIFT_CLK && hold_cnt == 32'(PDOWN_HOLD - 1);
   wire logic restart = pick_change || sync_hit || POWER_DOWN;

   // =========================================================
   // Conversion decoding
   wire logic conv_end = div_cnt == 9'(asr_pkg::CONV_CYCLES - 1);
   wire logic mod_en = !POWER_DOWN && div_cnt % 9'(asr_pkg::MOD_DIV) == '0;
   wire logic dec_en = mod_en && div_cnt == '0 && !restart;
   // Filter must not decimate on the publishing clock
   wire logic filter_dec = conv_end ? 1'b0 : dec_en;
   wire logic settled = settle == 3'(asr_pkg::SETTLE_CONVS);
   wire logic publish = conv_end && settled && !restart;

   // =========================================================
   // Output word control
   wire logic last_bit = bits_left == 5'h01;
   wire logic load_word = state == ST_WAIT && next_state == ST_READY;
   wire logic shift_bit = next_state == ST_SHIFT && sclk_rise;
   wire logic count_bit = state == ST_SHIFT && sclk_fall;

   always_comb begin
      next_state = state;
      // A word is refused while reading or with the clock high
      unique case (state)
         ST_WAIT:
            if (publish && !SHIFT_CLK)
               next_state = ST_READY;
         ST_READY:
            if (restart)
               next_state = ST_WAIT;
            else if (sclk_rise)
               next_state = ST_SHIFT;
         ST_SHIFT:
            if (restart)
               next_state = ST_WAIT;
            else if (sclk_fall && last_bit)
               next_state = ST_WAIT;
      endcase
   end

   // =========================================================
   // Channel pick capture
   // Falling edge gives picks changed after a rise half a cycle
   always_ff @(negedge SYS_CLK or negedge RST_N) begin
      if (!RST_N)
         pick_fall <= asr_pkg::CHAN_RESET;
      else if (CE)
         pick_fall <= pick;
   end

   // =========================================================
   // Conversion timing and settling
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         div_cnt <= '0;
         pick_q <= asr_pkg::CHAN_RESET;
      end else if (CE) begin
         pick_q <= pick_fall;
         div_cnt <= (restart || conv_end) ? '0 : div_cnt + 9'h001;
      end
   end

   // Counts finished conversions since the last restart
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N)
         settle <= '0;
      else if (CE) begin
         if (restart)
            settle <= '0;
         else if (conv_end && !settled)
            settle <= settle + 3'h1;
      end
   end

   // =========================================================
   // Shift clock hold detection
   // Counter stops at the power-down point so it never wraps
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sclk_q <= 1'b0;
         hold_cnt <= '0;
      end else if (CE) begin
         sclk_q <= SHIFT_CLK;
         if (!SHIFT_CLK)
            hold_cnt <= '0;
         else if (!pdown_hit && hold_cnt != 32'hffffffff)
            hold_cnt <= hold_cnt + 32'h1;
      end
   end

   // Sync pulse for one clock; power-down until the clock drops
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         MOD_RESET <= 1'b0;
         POWER_DOWN <= 1'b0;
      end else if (CE) begin
         MOD_RESET <= sync_hit;
         if (pdown_hit)
            POWER_DOWN <= 1'b1;
         else if (!SHIFT_CLK)
            POWER_DOWN <= 1'b0;
      end
   end

   // =========================================================
   // Output shift register and line
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= ST_WAIT;
         CHANNEL <= asr_pkg::CHAN_RESET;
      end else if (CE) begin
         state <= next_state;
         CHANNEL <= pick_fall;
      end
   end

   // Bits leave from the top, one per rise
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         shreg <= '0;
         bits_left <= '0;
      end else if (CE) begin
         if (load_word) begin
            shreg <= result;
            bits_left <= 5'(RES_W);
         end else if (shift_bit)
            shreg <= {shreg[RES_W-2:0], 1'b0};
         else if (count_bit)
            bits_left <= bits_left - 5'h01;
      end
   end

   // An abort at a falling shift clock still frees the line
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N)
         SERIAL_OUT_READY_LINE <= 1'b1;
      else if (CE) begin
         if (load_word)
            SERIAL_OUT_READY_LINE <= 1'b0;
         else if (shift_bit)
            SERIAL_OUT_READY_LINE <= shreg[RES_W-1];
         else if (count_bit && last_bit)
            SERIAL_OUT_READY_LINE <= 1'b1;
         else if (next_state == ST_WAIT)
            SERIAL_OUT_READY_LINE <= 1'b1;
      end
   end

   asr_sinc_filter #(
      .OUT_W(RES_W),
      .ACC_W(32)
   ) u_filter (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .ce(CE),
      .clear(restart),
      .mod_en(mod_en),
      .mod_bit(MOD_BIT),
      .dec_en(filter_dec),
      .result(result)
   );
endmodule

// ===== test/asr_readout_properties.sv
// Port checks on the converter readout block.
// Assumes one system clock and a bind to every readout instance.
module asr_readout_properties #(
   parameter int SYNC_HOLD = asr_pkg::SYNC_HOLD, // Clocks high to sync
   parameter int PDOWN_HOLD = asr_pkg::PDOWN_HOLD // Clocks high to power down
) (
   input wire logic SYS_CLK, // System clock
   input wire logic RST_N, // Reset, active low
   input wire logic CE, // Clock enable
   input wire logic SHIFT_CLK, // Host serial clock
   input wire logic CHANNEL_PICK_LO, // Pick low bit
   input wire logic CHANNEL_PICK_HI, // Pick high bit
   input wire logic SERIAL_OUT_READY_LINE, // Data out / ready
   input wire logic [1:0] CHANNEL, // Routed channel
   input wire logic MOD_RESET, // Sync pulse
   input wire logic POWER_DOWN // Power-down state
);
   // ==========================================
   // Run of shift clock high samples
   logic [31:0] high_run;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N)
         high_run <= '0;
      else if (CE)
         high_run <= SHIFT_CLK ? high_run + 32'h1 : '0;
   end
   // ==========================================
   // Assertions
   default clocking dc @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   a_sync_one_pulse: assert property (MOD_RESET |=> !MOD_RESET)
      else $error("sync pulse longer than one clock");
   a_sync_after_hold: assert property ($rose(MOD_RESET) |->
      high_run == 32'(SYNC_HOLD)) else $error("sync at wrong hold");
   a_pdown_after_hold: assert property ($rose(POWER_DOWN) |->
      high_run == 32'(PDOWN_HOLD)) else $error("pdown at wrong hold");
   a_ce_freeze: assert property (!CE |=> $stable(CHANNEL) &&
      $stable(SERIAL_OUT_READY_LINE) && $stable(POWER_DOWN))
      else $error("state moved with clock enable low");
   a_pdown_exit: assert property (POWER_DOWN && !SHIFT_CLK |->
      ##[1:2] !POWER_DOWN) else $error("power-down not left");
   a_pdown_quiet: assert property ($past(POWER_DOWN) && POWER_DOWN |->
      SERIAL_OUT_READY_LINE && !MOD_RESET) else $error("active in pdown");
   a_chan_copy: assert property ($past(CE) |-> CHANNEL ==
      $past({CHANNEL_PICK_HI, CHANNEL_PICK_LO})) else $error("bad channel");
   a_sync_abort: assert property (MOD_RESET |=>
      SERIAL_OUT_READY_LINE [*8]) else $error("line low after sync");
   a_pick_abort: assert property ($changed({CHANNEL_PICK_HI,
      CHANNEL_PICK_LO}) |-> ##[1:3] SERIAL_OUT_READY_LINE [*8])
      else $error("line low after pick change");
endmodule

bind asr_readout asr_readout_properties #(.SYNC_HOLD(SYNC_HOLD),
   .PDOWN_HOLD(PDOWN_HOLD)) i_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
   .CE(CE), .SHIFT_CLK(SHIFT_CLK), .CHANNEL_PICK_LO(CHANNEL_PICK_LO),
   .CHANNEL_PICK_HI(CHANNEL_PICK_HI), .CHANNEL(CHANNEL),
   .SERIAL_OUT_READY_LINE(SERIAL_OUT_READY_LINE),
   .MOD_RESET(MOD_RESET), .POWER_DOWN(POWER_DOWN));

// ===== test/asr_host_model.sv
// Host model that clocks results out of the converter.
// Assumes the converter samples the shift clock on the system clock.
module asr_host_model (
   input wire logic clk, // System clock
   input wire logic line, // Data out / ready line
   output logic shift_clk // Serial clock, idle low
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Read and hold tasks
   initial shift_clk = 1'b0;
   task automatic read_word(output logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         @(posedge clk) #1 shift_clk = 1'b1;
         repeat (3) @(posedge clk);
         #1 w[i] = line;
         shift_clk = 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
   task automatic set_high(input logic v);
      @(posedge clk) #1 shift_clk = v;
   endtask
endmodule

// ===== test/asr_readout_tb_top.sv
// Self-checking bench of the readout block.
// Assumes hold windows shortened to 16 and 64 clocks.
module asr_readout_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   `define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
      miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, g); \
   end end
   localparam int C = asr_pkg::CONV_CYCLES;
   logic sys_clk = 1'b0, rst_n = 1'b0, mod_bit = 1'b1;
   logic pick_lo = 1'b0, pick_hi = 1'b0;
   logic ce = 1'b1;
   wire logic shift_clk, line, mod_reset, power_down;
   wire logic [1:0] channel;
   int miscompares = 0, check_count = 0, n = 0, tick = 0, t0 = 0;
   logic [23:0] w1, w;
   logic [3:0] rows [4] = '{4'h0, 4'ha, 4'h5, 4'hf}; // Pick, channel
   asr_readout #(.SYNC_HOLD(16), .PDOWN_HOLD(64)) i_asr_readout (
      .SYS_CLK(sys_clk), .RST_N(rst_n), .CE(ce), .SHIFT_CLK(shift_clk),
      .CHANNEL_PICK_LO(pick_lo), .CHANNEL_PICK_HI(pick_hi),
      .MOD_BIT(mod_bit), .SERIAL_OUT_READY_LINE(line), .CHANNEL(channel),
      .MOD_RESET(mod_reset), .POWER_DOWN(power_down));
   asr_host_model i_asr_host_model (.clk(sys_clk), .line(line),
      .shift_clk(shift_clk));
   // ==========================================
   // Clock, tasks and sequence
   initial forever #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) tick <= tick + 1;
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wait_for(input int sel, input int max);
      n = 0;
      while (!(sel == 0 ? line === 1'b0 : sel == 1 ? mod_reset === 1'b1
            : power_down === 1'b1)) begin
         if (n++ == max) begin
            miscompares++;
            end_of_test();
         end
         @(posedge sys_clk) #1;
      end
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      #1 `CHK("line", 1'b1, line)
      `CHK("pdown", 1'b0, power_down)
      rst_n = 1'b1;
      foreach (rows[i]) begin
         {pick_hi, pick_lo} = rows[i][3:2];
         repeat (2) @(posedge sys_clk) #1;
         `CHK("chan", rows[i][1:0], channel)
      end
      wait_for(0, 7 * C);
      `CHK("settle", 1'b1, n + 2 >= 5 * C)
      t0 = tick;
      i_asr_host_model.read_word(w1);
      repeat (2) @(posedge sys_clk) #1;
      `CHK("idle", 1'b1, line)
      wait_for(0, C);
      `CHK("period", C, tick - t0)
      mod_bit = 1'b0;
      repeat (7) begin
         i_asr_host_model.read_word(w);
         wait_for(0, C);
      end
      `CHK("sign", ~w1[23], w[23])
      i_asr_host_model.set_high(1'b1);
      wait_for(1, 20);
      `CHK("sync at", 1'b1, n >= 14)
      wait_for(2, 64);
      i_asr_host_model.set_high(1'b0);
      repeat (3) @(posedge sys_clk) #1;
      `CHK("wake", 1'b0, power_down)
      ce = 1'b0;
      {pick_hi, pick_lo} = 2'h0;
      repeat (3) @(posedge sys_clk) #1;
      `CHK("freeze", 2'h3, channel)
      ce = 1'b1;
      repeat (2) @(posedge sys_clk) #1;
      `CHK("thaw", 2'h0, channel)
      end_of_test();
   end
endmodule
